// ---- common/adc_trig_pkg.sv ----
package adc_trig_pkg;

  // register byte addresses on the APB side
  localparam logic [7:0] ADDR_CONV_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SHARED_CTRL = 8'h04;
  localparam logic [7:0] ADDR_TRIG_CTRL = 8'h08;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_RES_LOW = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // converter control layout
  localparam int CONV_ENABLE_BIT = 0;
  localparam int CONV_START_BIT = 1;
  localparam int CONV_CHAN_LSB = 2;
  localparam int CHAN_W = 5;

  // shared control layout
  localparam int SHARED_REF_LSB = 0;
  localparam int REF_W = 2;
  localparam int SHARED_CLKSEL_LSB = 4;
  localparam int CLKSEL_W = 3;
  localparam int SHARED_JUSTIFY_BIT = 7;

  // auto trigger control layout
  localparam int TRIG_SEL_LSB = 4;
  localparam int TRIG_SEL_W = 3;

  // auto trigger select codes
  localparam logic [2:0] TRIG_NONE = 3'h0;
  localparam logic [2:0] TRIG_RSVD1 = 3'h1;
  localparam logic [2:0] TRIG_RSVD2 = 3'h2;
  localparam logic [2:0] TRIG_TIMER_ZERO = 3'h3;
  localparam logic [2:0] TRIG_TIMER_ONE = 3'h4;
  localparam logic [2:0] TRIG_TIMER_TWO = 3'h5;
  localparam logic [2:0] TRIG_EXT_PIN = 3'h6;

  // interrupt status / mask layout
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TIMER_ZERO_BIT = 1;
  localparam int IRQ_TIMER_ONE_BIT = 2;
  localparam int IRQ_TIMER_TWO_BIT = 3;

  // widths and reset values
  localparam int RESULT_W = 10;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  localparam logic [2:0] TRIG_SEL_RESET = 3'h0;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 5'h00;
  localparam logic [CLKSEL_W-1:0] CLKSEL_RESET = 3'h0;
  localparam logic [REF_W-1:0] REF_RESET = 2'h0;
  localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

  // high byte of a result in the chosen justification
  function automatic logic [7:0] format_high(input logic [RESULT_W-1:0] res,
                                             input logic right);
    format_high = right ? {6'h00, res[9:8]} : res[9:2];
  endfunction

  // low byte of a result in the chosen justification
  function automatic logic [7:0] format_low(input logic [RESULT_W-1:0] res,
                                            input logic right);
    format_low = right ? res[7:0] : {res[1:0], 6'h00};
  endfunction

endpackage

// ---- verilog/pin_edge_sync.sv ----
`timescale 1ns/1ps
module pin_edge_sync (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // pin and detected edge
  input wire logic pin_i,
  output logic rise_o
);

  typedef struct packed {
    logic meta;
    logic stable;
    logic last;
    logic rise;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.meta = pin_i;
    next_s.stable = s.meta;
    next_s.last = s.stable;
    // edge looks only at the second and third stages
    next_s.rise = s.stable & ~s.last;
    if (rst_i) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    s <= next_s;
  end

  assign rise_o = s.rise;

endmodule // pin_edge_sync

// ---- verilog/result_store.sv ----
`timescale 1ns/1ps
module result_store (
  // clock
  input wire logic clock_i,
  // software writes
  input wire logic sw_we_high_i,
  input wire logic sw_we_low_i,
  input wire logic [7:0] sw_wdata_i,
  // converter load
  input wire logic hw_load_i,
  input wire logic [adc_trig_pkg::RESULT_W-1:0] hw_data_i,
  input wire logic justify_right_i,
  // stored bytes
  output logic [7:0] high_o,
  output logic [7:0] low_o
);

  import adc_trig_pkg::*;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } store_state_t;

  store_state_t s;
  store_state_t next_s;

  // no reset on purpose: contents survive every reset but power-up
  always_comb begin
    next_s = s;
    if (hw_load_i) begin
      next_s.high = format_high(hw_data_i, justify_right_i);
      next_s.low = format_low(hw_data_i, justify_right_i);
    end else begin
      if (sw_we_high_i) begin
        next_s.high = sw_wdata_i;
      end
      if (sw_we_low_i) begin
        next_s.low = sw_wdata_i;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    s <= next_s;
  end

  assign high_o = s.high;
  assign low_o = s.low;

endmodule // result_store

// ---- verilog/adc_trigger_top.sv ----
// Notes on behaviour
// - trigger select bits 6-4: 0 none, 3/4/5 timers, 6 pin rising edge.
// - selected timer events still set their own timer flags.
// - left justified: result bits 9-2 go to high byte.
// - left justified: result bits 1-0 go to low bits 7-6.
// - right justified: result bits 9-8 go to high bits 1-0.
// - right justified: result bits 7-0 fill the low byte.
// - result bytes writable, unknown at power-up, kept over other resets.
// - hold capacitor is never discharged at conversion end.
// - justify bit set is right, clear is left; unused bits load zero.
// - trigger starts like the start bit; start bit reads set meanwhile.
// - on done: load result, clear start bit, set done flag.
`timescale 1ns/1ps
module adc_trigger_top (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // trigger sources
  input wire logic timer_zero_ovf_i,
  input wire logic timer_one_ovf_i,
  input wire logic timer_two_period_match_i,
  input wire logic external_trigger_pin_i,
  // converter core
  input wire logic conv_done_i,
  input wire logic [adc_trig_pkg::RESULT_W-1:0] conversion_result_i,
  output logic conv_start_o,
  output logic conv_abort_o,
  output logic conv_enable_o,
  output logic [adc_trig_pkg::CHAN_W-1:0] channel_o,
  output logic [adc_trig_pkg::CLKSEL_W-1:0] conv_clock_sel_o,
  output logic [adc_trig_pkg::REF_W-1:0] ref_sel_o,
  output logic hold_discharge_o,
  // interrupt
  output logic irq_o
);

  import adc_trig_pkg::*;

  typedef struct packed {
    logic enable;
    logic start_flag;
    logic [CHAN_W-1:0] channel;
    logic [CLKSEL_W-1:0] clk_sel;
    logic [REF_W-1:0] ref_sel;
    logic justify_right;
    logic [TRIG_SEL_W-1:0] trig_sel;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic start_pulse;
    logic abort_pulse;
    logic hold_discharge;
    logic irq;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;

  logic ext_rise;
  logic [7:0] res_high;
  logic [7:0] res_low;
  logic hw_load;
  logic sw_we_high;
  logic sw_we_low;

  pin_edge_sync u_pin_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(external_trigger_pin_i),
    .rise_o(ext_rise)
  );

  result_store u_result (
    .clock_i(clock_i),
    .sw_we_high_i(sw_we_high),
    .sw_we_low_i(sw_we_low),
    .sw_wdata_i(pwdata_i[7:0]),
    .hw_load_i(hw_load),
    .hw_data_i(conversion_result_i),
    .justify_right_i(s.justify_right),
    .high_o(res_high),
    .low_o(res_low)
  );

  // pick the auto trigger source; reserved codes select nothing
  function automatic logic pick_trigger(input logic [2:0] sel,
                                        input logic t0,
                                        input logic t1,
                                        input logic t2,
                                        input logic pin);
    case (sel)
      TRIG_TIMER_ZERO: pick_trigger = t0;
      TRIG_TIMER_ONE: pick_trigger = t1;
      TRIG_TIMER_TWO: pick_trigger = t2;
      TRIG_EXT_PIN: pick_trigger = pin;
      TRIG_NONE, TRIG_RSVD1, TRIG_RSVD2: pick_trigger = 1'b0;
      default: pick_trigger = 1'b0;
    endcase
  endfunction

  logic setup_phase;
  logic write_now;
  logic conv_write;
  logic trig;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  always_comb begin
    next_s = s;
    hw_load = 1'b0;
    irq_set = '0;
    irq_clr = '0;
    next_s.start_pulse = 1'b0;
    next_s.abort_pulse = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    setup_phase = psel_i & ~penable_i;
    // writes land only at the edge where the access completes
    write_now = psel_i & penable_i & s.pready & pwrite_i;
    conv_write = write_now & (paddr_i == ADDR_CONV_CTRL);
    sw_we_high = write_now & (paddr_i == ADDR_RES_HIGH);
    sw_we_low = write_now & (paddr_i == ADDR_RES_LOW);
    trig = pick_trigger(s.trig_sel, timer_zero_ovf_i, timer_one_ovf_i,
                        timer_two_period_match_i, ext_rise);

    // timer events keep raising their own flags whatever is selected
    irq_set[IRQ_TIMER_ZERO_BIT] = timer_zero_ovf_i;
    irq_set[IRQ_TIMER_ONE_BIT] = timer_one_ovf_i;
    irq_set[IRQ_TIMER_TWO_BIT] = timer_two_period_match_i;

    // register writes other than the start bit
    if (write_now) begin
      case (paddr_i)
        ADDR_CONV_CTRL: begin
          next_s.enable = pwdata_i[CONV_ENABLE_BIT];
          // channel change: acquisition wait is software's job
          next_s.channel = pwdata_i[CONV_CHAN_LSB +: CHAN_W];
        end
        ADDR_SHARED_CTRL: begin
          next_s.justify_right = pwdata_i[SHARED_JUSTIFY_BIT];
          next_s.clk_sel = pwdata_i[SHARED_CLKSEL_LSB +: CLKSEL_W];
          next_s.ref_sel = pwdata_i[SHARED_REF_LSB +: REF_W];
        end
        ADDR_TRIG_CTRL: begin
          next_s.trig_sel = pwdata_i[TRIG_SEL_LSB +: TRIG_SEL_W];
        end
        ADDR_IRQ_STATUS: begin
          irq_clr = pwdata_i[IRQ_W-1:0];
        end
        ADDR_IRQ_MASK: begin
          next_s.mask = pwdata_i[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // conversion sequencing
    if (s.start_flag) begin
      if (conv_done_i) begin
        hw_load = 1'b1;
        next_s.start_flag = 1'b0;
        irq_set[IRQ_DONE_BIT] = 1'b1;
      end else if ((conv_write & ~pwdata_i[CONV_START_BIT]) |
                   (conv_write & ~pwdata_i[CONV_ENABLE_BIT])) begin
        // early stop keeps the partial result but raises no flag
        hw_load = 1'b1;
        next_s.start_flag = 1'b0;
        next_s.abort_pulse = 1'b1;
      end
      // a trigger here is simply dropped
    // a write that switches the converter off starts nothing
    end else if (s.enable & ~(conv_write & ~pwdata_i[CONV_ENABLE_BIT]) &
                 (trig | (conv_write & pwdata_i[CONV_START_BIT]))) begin
      next_s.start_flag = 1'b1;
      next_s.start_pulse = 1'b1;
    end

    // the hold switch is left alone between conversions
    next_s.hold_discharge = s.hold_discharge;

    // set wins over a software clear in the same cycle
    next_s.status = (s.status & ~irq_clr) | irq_set;
    next_s.irq = |(next_s.status & next_s.mask);

    // read data and error are prepared in the setup cycle
    if (setup_phase) begin
      next_s.pready = 1'b1;
      next_s.prdata = PRDATA_RESET;
      case (paddr_i)
        ADDR_CONV_CTRL: begin
          next_s.prdata[CONV_ENABLE_BIT] = s.enable;
          next_s.prdata[CONV_START_BIT] = s.start_flag;
          next_s.prdata[CONV_CHAN_LSB +: CHAN_W] = s.channel;
        end
        ADDR_SHARED_CTRL: begin
          next_s.prdata[SHARED_JUSTIFY_BIT] = s.justify_right;
          next_s.prdata[SHARED_CLKSEL_LSB +: CLKSEL_W] = s.clk_sel;
          next_s.prdata[SHARED_REF_LSB +: REF_W] = s.ref_sel;
        end
        ADDR_TRIG_CTRL: begin
          next_s.prdata[TRIG_SEL_LSB +: TRIG_SEL_W] = s.trig_sel;
        end
        ADDR_RES_HIGH: begin
          next_s.prdata[7:0] = res_high;
        end
        ADDR_RES_LOW: begin
          next_s.prdata[7:0] = res_low;
        end
        ADDR_IRQ_STATUS: begin
          next_s.prdata[IRQ_W-1:0] = s.status;
        end
        ADDR_IRQ_MASK: begin
          next_s.prdata[IRQ_W-1:0] = s.mask;
        end
        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
    end

    if (rst_i) begin
      next_s = '0;
      next_s.channel = CHAN_RESET;
      next_s.clk_sel = CLKSEL_RESET;
      next_s.ref_sel = REF_RESET;
      next_s.trig_sel = TRIG_SEL_RESET;
      next_s.status = IRQ_RESET;
      next_s.mask = IRQ_RESET;
      next_s.prdata = PRDATA_RESET;
    end
  end

  always_ff @(posedge clock_i) begin
    s <= next_s;
  end

  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign conv_start_o = s.start_pulse;
  assign conv_abort_o = s.abort_pulse;
  assign conv_enable_o = s.enable;
  assign channel_o = s.channel;
  assign conv_clock_sel_o = s.clk_sel;
  assign ref_sel_o = s.ref_sel;
  assign hold_discharge_o = s.hold_discharge;
  assign irq_o = s.irq;

endmodule // adc_trigger_top

// ---- tb/adc_trig_checker_assertions.sv ----
`timescale 1ns/1ps
module adc_trig_checker (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // converter
  input wire logic conv_done_i,
  input wire logic conv_start_o,
  input wire logic conv_abort_o,
  input wire logic conv_enable_o,
  input wire logic hold_discharge_o
);
  logic busy;
  // conversion runs from its start pulse until done or abort
  always_ff @(posedge clock_i) begin
    if (rst_i || conv_done_i || conv_abort_o)
      busy <= 1'b0;
    else if (conv_start_o)
      busy <= 1'b1;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_hold_stays_off: assert property (!hold_discharge_o)
    else $error("hold discharge driven");
  a_start_needs_enable: assert property (conv_start_o |-> conv_enable_o)
    else $error("start while disabled");
  a_abort_while_busy: assert property (conv_abort_o |-> busy)
    else $error("abort with no conversion");
  a_start_one_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse too long");
  a_busy_no_start: assert property (busy |-> !conv_start_o)
    else $error("start during conversion");
  a_done_no_restart: assert property (conv_done_i |=> !conv_start_o)
    else $error("start right after done");
  a_setup_gets_ready: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_error_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  c_start: cover property (conv_start_o);
  c_abort: cover property (conv_abort_o);
  c_error: cover property (pslverr_o);
endmodule // adc_trig_checker

bind adc_trigger_top adc_trig_checker u_chk (.clock_i, .rst_i, .psel_i,
  .penable_i, .pready_o, .pslverr_o, .conv_done_i, .conv_start_o,
  .conv_abort_o, .conv_enable_o, .hold_discharge_o);

// ---- tb/adc_trigger_and_result_format_bench.sv ----
`timescale 1ns/1ps
module adc_trigger_and_result_format_bench;
  import adc_trig_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  // timer zero, timer one, timer two, pin
  logic [3:0] src = 4'h0;
  logic conv_done_i = 1'b0;
  logic [9:0] conversion_result_i = 10'h000;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, conv_start_o, conv_abort_o, irq_o, err;
  logic conv_enable_o, hold_discharge_o;
  logic [CHAN_W-1:0] channel_o;
  logic [CLKSEL_W-1:0] conv_clock_sel_o;
  logic [REF_W-1:0] ref_sel_o;
  int mismatches = 0, n_checks = 0, n_starts = 0, n_aborts = 0;

  adc_trigger_top uut (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .timer_zero_ovf_i(src[0]), .timer_one_ovf_i(src[1]),
    .timer_two_period_match_i(src[2]), .external_trigger_pin_i(src[3]),
    .conv_done_i, .conversion_result_i, .conv_start_o, .conv_abort_o,
    .conv_enable_o, .channel_o, .conv_clock_sel_o, .ref_sel_o,
    .hold_discharge_o, .irq_o);

  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    if (conv_start_o === 1'b1)
      n_starts++;
    if (conv_abort_o === 1'b1)
      n_aborts++;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    int n;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    chk(pready_o, 1'b1);
    r = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask

  task done(input logic [9:0] v);
    @(posedge clock_i);
    conv_done_i <= 1'b1;
    conversion_result_i <= v;
    @(posedge clock_i);
    conv_done_i <= 1'b0;
    // result lines are only valid with done
    conversion_result_i <= ~v;
  endtask

  task pulse(input int s);
    @(posedge clock_i);
    src <= 4'h1 << s;
    @(posedge clock_i);
    src <= 4'h0;
  endtask

  task t_regs;
    // start request while the converter is off is refused
    wr(ADDR_CONV_CTRL, 32'h0000_0002);
    rdc(ADDR_CONV_CTRL, 32'h0000_0000);
    chk(n_starts, 0);
    chk(hold_discharge_o, 1'b0);
    wr(ADDR_SHARED_CTRL, 32'h0000_0053);
    rdc(ADDR_SHARED_CTRL, 32'h0000_0053);
    chk(conv_clock_sel_o, 3'h5);
    chk(ref_sel_o, 2'h3);
    rdc(ADDR_TRIG_CTRL, 32'h0000_0000);
    wr(ADDR_RES_HIGH, 32'h0000_00a5);
    wr(ADDR_RES_LOW, 32'h0000_005a);
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    rdc(ADDR_RES_HIGH, 32'h0000_00a5);
    rdc(ADDR_RES_LOW, 32'h0000_005a);
    chk(conv_clock_sel_o, 3'h0);
    chk(ref_sel_o, 2'h0);
    rdc(8'h1c, 32'h0000_0000);
    chk(err, 1'b1);
    $display("regs test done");
  endtask

  task t_format;
    logic [9:0] v;
    v = 10'h2d7;
    wr(ADDR_CONV_CTRL, 32'h0000_0009);
    // acquisition time after the channel change, before any start
    repeat (8) @(posedge clock_i);
    chk(channel_o, 5'h02);
    chk(conv_enable_o, 1'b1);
    for (int j = 0; j < 2; j++) begin
      wr(ADDR_SHARED_CTRL, j ? 32'h0000_0080 : 32'h0000_0000);
      wr(ADDR_RES_HIGH, 32'h0000_00ff);
      wr(ADDR_RES_LOW, 32'h0000_00ff);
      wr(ADDR_CONV_CTRL, 32'h0000_000b);
      rdc(ADDR_CONV_CTRL, 32'h0000_000b);
      done(v);
      rdc(ADDR_CONV_CTRL, 32'h0000_0009);
      rdc(ADDR_IRQ_STATUS, 32'h0000_0001);
      if (j) begin
        rdc(ADDR_RES_HIGH, v[9:8]);
        rdc(ADDR_RES_LOW, v[7:0]);
      end else begin
        rdc(ADDR_RES_HIGH, v[9:2]);
        rdc(ADDR_RES_LOW, {v[1:0], 6'h00});
      end
      wr(ADDR_IRQ_STATUS, 32'h0000_000f);
      v = ~v;
    end
    $display("format test done");
  endtask

  task t_trig;
    int s0;
    logic hit;
    for (int c = 0; c < 7; c++) begin
      wr(ADDR_TRIG_CTRL, 32'(c) << 4);
      rdc(ADDR_TRIG_CTRL, 32'(c) << 4);
      for (int s = 0; s < 4; s++) begin
        hit = (c == s + 3);
        s0 = n_starts;
        pulse(s);
        repeat (6) @(posedge clock_i);
        chk(n_starts - s0, hit);
        if (hit)
          done(10'h155);
        rdc(ADDR_IRQ_STATUS, (s < 3 ? 32'h2 << s : 32'h0) | hit);
        wr(ADDR_IRQ_STATUS, 32'h0000_000f);
      end
    end
    $display("trigger test done");
  endtask

  task t_busy;
    int s0, a0;
    s0 = n_starts;
    a0 = n_aborts;
    wr(ADDR_TRIG_CTRL, 32'h0000_0030);
    pulse(0);
    repeat (2) @(posedge clock_i);
    pulse(0);
    wr(ADDR_CONV_CTRL, 32'h0000_000b);
    done(10'h0aa);
    repeat (6) @(posedge clock_i);
    chk(n_starts - s0, 1);
    wr(ADDR_IRQ_STATUS, 32'h0000_000f);
    pulse(0);
    @(posedge clock_i);
    conversion_result_i <= 10'h3c1;
    wr(ADDR_CONV_CTRL, 32'h0000_0009);
    repeat (3) @(posedge clock_i);
    chk(n_aborts - a0, 1);
    chk(n_starts - s0, 2);
    rdc(ADDR_IRQ_STATUS, 32'h0000_0002);
    rdc(ADDR_RES_LOW, 32'h0000_00c1);
    // switching the converter off also stops a running conversion
    pulse(0);
    repeat (4) @(posedge clock_i);
    wr(ADDR_CONV_CTRL, 32'h0000_000a);
    repeat (3) @(posedge clock_i);
    chk(n_aborts - a0, 2);
    chk(n_starts - s0, 3);
    rdc(ADDR_CONV_CTRL, 32'h0000_0008);
    chk(conv_enable_o, 1'b0);
    $display("busy test done");
  endtask

  task t_irq;
    // timer zero status bit is still pending from the busy test
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge clock_i);
    chk(irq_o, 1'b1);
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge clock_i);
    chk(irq_o, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    wr(ADDR_IRQ_STATUS, 32'h0000_0002);
    repeat (2) @(posedge clock_i);
    chk(irq_o, 1'b0);
    $display("irq test done");
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    t_regs;
    t_format;
    t_trig;
    t_busy;
    t_irq;
    wrap_up;
  end

  // whole run takes several hundred cycles
  initial begin
    #500000;
    mismatches++;
    wrap_up;
  end
endmodule // adc_trigger_and_result_format_bench
